/* File: rtl/line_sampler.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-stage sampler with edge outputs for the bus lines.
module line_sampler
    import touch_port_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);

    logic scl_r;
    logic sda_r;
    logic scl_d_r;
    logic sda_d_r;

    // Idle bus is high, so reset to high avoids a false start.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_r <= scl_in;
            sda_r <= sda_in;
            scl_d_r <= scl_r;
            sda_d_r <= sda_r;
        end
    end

    assign scl_out = scl_r;
    assign sda_out = sda_r;
    assign scl_rise_out = scl_r && !scl_d_r;
    assign scl_fall_out = !scl_r && scl_d_r;
    assign start_out = scl_r && scl_d_r && !sda_r && sda_d_r; // RULE4
    assign stop_out = scl_r && scl_d_r && sda_r && !sda_d_r; // RULE4

endmodule

`default_nettype wire

/* File: rtl/touch_i2c_port.sv */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: Port is slave only; it never begins a transfer on the bus.
// RULE2: Host keeps the bus rate at or below 400 kbit/s.
// RULE3: Port answers pair 0xBA/0xBB or 0x28/0x29, chosen at power-on.
// RULE4: Start and stop are SDA edges while SCL is high, seen anytime.
// RULE5: Matching address byte is acknowledged by holding SDA low in bit nine.
// RULE6: Unmatched address gets no acknowledge; port idles until next start.
// RULE7: A byte is eight data bits plus one acknowledge bit from the receiver.
// RULE8: SDA is sampled only while SCL is high; driver holds it stable.
// RULE9: Host write: address, two register address bytes, then data bytes.
// RULE10: Register pointer increments by one after every written byte.
// RULE11: Write burst runs until the host sends stop; port then idles.
// RULE12: Host read: set pointer by write, repeated start, read address.
// RULE13: Port supplies bytes as long as the host keeps acknowledging.
// RULE14: Host acknowledges all bytes but the last, then sends stop.
// RULE15: Touch reset is active low and holds the port in reset.
// RULE16: Controller drives an interrupt line toward the host.
// RULE17: Register pointer increments by one after each byte read.
// RULE18: Address pair latched at end of initialization, kept until reset.
module touch_i2c_port
    import touch_port_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic int_strap_in,
    input wire logic init_done_in,
    input wire logic event_in,
    output logic int_out,
    output logic wr_en_out,
    output logic [REG_ADDR_W-1:0] reg_addr_out,
    output logic [DATA_W-1:0] wr_data_out,
    output logic rd_en_out,
    input wire logic [DATA_W-1:0] rd_data_in,
    output logic pair_b_out
);

    // ------------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    line_sampler u_sampler (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_out(scl_s),
        .sda_out(sda_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_det),
        .stop_out(stop_det)
    );

    // ------------------------------------------------------------------
    // Address pair selection
    // ------------------------------------------------------------------
    logic pair_b_r;
    logic pair_locked_r;

    // The strap is caught by a clocked load, never by the reset itself.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pair_b_r <= 1'b0;
            pair_locked_r <= 1'b0;
        end else if (!pair_locked_r && init_done_in) begin
            pair_b_r <= int_strap_in; // RULE18
            pair_locked_r <= 1'b1; // RULE18
        end
    end

    wire [6:0] own_addr = pair_b_r ? ADDR_PAIR_B : ADDR_PAIR_A; // RULE3

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    port_state_t state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [1:0] addr_phase_r, addr_phase_nxt;
    logic [REG_ADDR_W-1:0] ptr_r, ptr_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic wr_en_r, wr_en_nxt;
    logic rd_en_r, rd_en_nxt;
    logic [DATA_W-1:0] wr_data_r, wr_data_nxt;

    wire byte_done = scl_rise && (bit_cnt_r == 4'(BITS_PER_BYTE - 1));
    wire [7:0] shifted = {shift_r[6:0], sda_s}; // RULE8
    wire addr_match = (shifted[7:1] == own_addr);
    wire host_ack = !sda_s;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        addr_phase_nxt = addr_phase_r;
        ptr_nxt = ptr_r;
        sda_oe_nxt = sda_oe_r;
        wr_en_nxt = 1'b0;
        rd_en_nxt = 1'b0;
        wr_data_nxt = wr_data_r;
        if (stop_det) begin
            state_nxt = ST_IDLE; // RULE11
            sda_oe_nxt = 1'b0;
        end else if (start_det) begin
            state_nxt = ST_ADDR; // RULE4
            bit_cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    sda_oe_nxt = 1'b0; // RULE1
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_nxt = shifted; // RULE7
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (byte_done && state_r == ST_ADDR) begin
                        if (addr_match) begin
                            state_nxt = ST_ADDR_ACK; // RULE5
                            if (!shifted[0]) begin
                                addr_phase_nxt = 2'h0;
                            end
                        end else begin
                            state_nxt = ST_IDLE; // RULE6
                        end
                    end else if (byte_done) begin
                        state_nxt = ST_WRITE_ACK;
                        if (addr_phase_r == 2'h0) begin
                            ptr_nxt = {shifted, ptr_r[7:0]};
                            addr_phase_nxt = 2'h1;
                        end else if (addr_phase_r == 2'h1) begin
                            ptr_nxt = {ptr_r[15:8], shifted};
                            addr_phase_nxt = 2'h2;
                        end else begin
                            wr_data_nxt = shifted;
                            wr_en_nxt = 1'b1;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WRITE_ACK: begin
                    // Drive acknowledge across the whole ninth clock.
                    if (scl_fall && !sda_oe_r) begin
                        sda_oe_nxt = 1'b1; // RULE5
                    end else if (scl_fall && sda_oe_r) begin
                        bit_cnt_nxt = 4'h0;
                        if (state_r == ST_ADDR_ACK && shift_r[0]) begin
                            state_nxt = ST_READ; // RULE13
                            shift_nxt = rd_data_in;
                            sda_oe_nxt = !rd_data_in[7];
                        end else begin
                            state_nxt = ST_WRITE;
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'(BITS_PER_BYTE - 1)) begin
                            state_nxt = ST_READ_ACK; // RULE7
                            sda_oe_nxt = 1'b0;
                            bit_cnt_nxt = 4'h0;
                            rd_en_nxt = 1'b1;
                            ptr_nxt = ptr_r + 16'h0001; // RULE17
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sda_oe_nxt = !shift_r[6];
                            bit_cnt_nxt = bit_cnt_r + 4'h1;
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        // Not-acknowledge ends the burst; stop follows.
                        shift_nxt = {7'h00, host_ack};
                    end
                    if (scl_fall) begin
                        if (shift_r[0]) begin
                            state_nxt = ST_READ; // RULE13
                            shift_nxt = rd_data_in;
                            sda_oe_nxt = !rd_data_in[7];
                        end else begin
                            state_nxt = ST_IDLE; // RULE14
                        end
                    end
                end
            endcase
        end
        if (wr_en_r) begin
            ptr_nxt = ptr_r + 16'h0001; // RULE10
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin // RULE15
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            addr_phase_r <= 2'h0;
            ptr_r <= REG_PTR_RESET;
            sda_oe_r <= 1'b0;
            wr_en_r <= 1'b0;
            rd_en_r <= 1'b0;
            wr_data_r <= RD_DATA_RESET;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            addr_phase_r <= addr_phase_nxt;
            ptr_r <= ptr_nxt;
            sda_oe_r <= sda_oe_nxt;
            wr_en_r <= wr_en_nxt;
            rd_en_r <= rd_en_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------------
    logic int_r;

    // The line pulses with each event; the host reads the cause by bus.
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_r <= 1'b0;
        end else begin
            int_r <= event_in; // RULE16
        end
    end

    // Open-drain: the pin is only ever pulled low, never driven high.
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_r;
    assign int_out = int_r;
    assign wr_en_out = wr_en_r;
    assign wr_data_out = wr_data_r;
    assign rd_en_out = rd_en_r;
    assign reg_addr_out = ptr_r;
    assign pair_b_out = pair_b_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    a_idle_no_drive: assert property ( // RULE1
        state_r == ST_IDLE |-> !sda_oe_r)
        else $error("SDA driven while idle");
    a_addr_ack_low: assert property ( // RULE5
        state_r == ST_ADDR_ACK && scl_rise |-> sda_oe_out)
        else $error("Address acknowledge not held");
    a_nomatch_idle: assert property ( // RULE6
        state_r == ST_ADDR && byte_done && !addr_match && !start_det
        && !stop_det |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("Unmatched address not ignored");
    a_stop_idle: assert property ( // RULE11
        stop_det |=> state_r == ST_IDLE)
        else $error("Stop did not return to idle");
    a_start_addr: assert property ( // RULE4
        start_det && !stop_det |=> state_r == ST_ADDR && bit_cnt_r == 4'h0)
        else $error("Start not taken");
    a_wr_ptr_inc: assert property ( // RULE10
        wr_en_r |=> ptr_r == $past(ptr_r) + 16'h0001)
        else $error("Write pointer not advanced");
    a_rd_ptr_inc: assert property ( // RULE17
        rd_en_nxt |=> ptr_r == $past(ptr_r) + 16'h0001)
        else $error("Read pointer not advanced");
    a_pair_stable: assert property ( // RULE18
        pair_locked_r |=> $stable(pair_b_r))
        else $error("Address pair changed after lock");
    a_sda_stable_high: assert property ( // RULE8
        scl_s && $past(scl_s) && !$past(start_det) && !$past(stop_det)
        |-> $stable(sda_oe_r))
        else $error("SDA changed while SCL high");

    c_write: cover property (wr_en_r);
    c_read: cover property (state_r == ST_READ_ACK && scl_rise && host_ack);
    c_nomatch: cover property (state_r == ST_ADDR && byte_done
        && !addr_match);
    c_pair_b: cover property (pair_locked_r && pair_b_r);

endmodule

`default_nettype wire

/* File: shared/touch_port_pkg.sv */
package touch_port_pkg;

    // Seven-bit bus addresses of the two selectable pairs.
    localparam logic [6:0] ADDR_PAIR_A = 7'h5D;  // 0xBA write / 0xBB read
    localparam logic [6:0] ADDR_PAIR_B = 7'h14;  // 0x28 write / 0x29 read
    localparam int REG_ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [15:0] REG_PTR_RESET = 16'h0000;
    localparam logic [7:0] RD_DATA_RESET = 8'h00;

    // Latest nominal bus rate; the host keeps below this.
    localparam int BUS_RATE_KBPS = 400;
    localparam int CLK_MHZ = 250;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } port_state_t;

endpackage

/* File: verification/host_master.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host bus master model
// ----------------------------------------------------------------
// Open drain: the model only pulls a line low and the pull-up does
// the rest, so a released line reads high unless the port pulls SDA low.
module host_master #(
    parameter int HALF = 157
) (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    task automatic wait_h(input int n);
        repeat (n * HALF) @(negedge mclk_in);
    endtask

    // Four half slots per bit keep the rate just under 400 kbit/s.
    task automatic bit_io(input logic b, output logic r);
        wait_h(1);
        sda_low_out = ~b;
        wait_h(1);
        scl_low_out = 1'b0;
        wait_h(2);
        r = sda_in;
        scl_low_out = 1'b1;
    endtask

    // One half slot per phase still exceeds the start setup and hold times.
    task automatic bus_start();
        wait_h(1);
        sda_low_out = 1'b0;
        wait_h(1);
        scl_low_out = 1'b0;
        wait_h(1);
        sda_low_out = 1'b1;
        wait_h(1);
        scl_low_out = 1'b1;
    endtask

    task automatic bus_stop();
        wait_h(1);
        sda_low_out = 1'b1;
        wait_h(1);
        scl_low_out = 1'b0;
        wait_h(1);
        sda_low_out = 1'b0;
        wait_h(1);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic r);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], x);
        end
        bit_io(1'b1, r);
    endtask

    // A high ack value is a not-acknowledge, used for the last byte.
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(ack, x);
    endtask
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(act, exp, msg) \
    begin \
        comparisons++; \
        if ((act) !== (exp)) begin \
            bad_count++; \
            $display("FAIL %0t %s", $time, msg); \
        end \
    end

module testbench
    import touch_port_pkg::*;
();
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic int_strap_in = 1'b0;
    logic init_done_in = 1'b0;
    logic event_in = 1'b0;
    logic scl_low, sda_low, sda_out, sda_oe_out, int_out;
    logic wr_en_out, rd_en_out, pair_b_out;
    logic [REG_ADDR_W-1:0] reg_addr_out;
    logic [DATA_W-1:0] wr_data_out, rd_data_in;
    wire logic scl_line;
    wire logic sda_line;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int rd_count = 0;
    logic [23:0] wr_log[$];

    assign scl_line = ~scl_low;
    assign sda_line = ~(sda_low | (sda_oe_out & ~sda_out));
    // Register file stand-in: each address reads back a known pattern.
    assign rd_data_in = reg_addr_out[7:0] ^ 8'hC3;

    always #2 mclk_in = ~mclk_in;

    touch_i2c_port dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .int_strap_in(int_strap_in),
        .init_done_in(init_done_in), .event_in(event_in),
        .int_out(int_out), .wr_en_out(wr_en_out),
        .reg_addr_out(reg_addr_out), .wr_data_out(wr_data_out),
        .rd_en_out(rd_en_out), .rd_data_in(rd_data_in),
        .pair_b_out(pair_b_out));

    host_master #(.HALF(157)) host (.mclk_in(mclk_in), .sda_in(sda_line),
        .scl_low_out(scl_low), .sda_low_out(sda_low));

    // ------------------------------------------------------------
    // Monitors and closing report
    // ------------------------------------------------------------
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Strobes are sampled on the falling edge, where they have settled.
    always @(negedge mclk_in) begin
        cycles++;
        if (wr_en_out === 1'b1) begin
            wr_log.push_back({reg_addr_out, wr_data_out});
        end
        if (rd_en_out === 1'b1) begin
            rd_count++;
        end
        if (cycles == 98000) begin
            bad_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic tb_send(input logic [7:0] b, input logic exp_r);
        logic r;
        host.send_byte(b, r);
        `CHK(r, exp_r, "acknowledge bit")
    endtask

    task automatic t_reset(input logic strap);
        reset_n_in = 1'b0;
        repeat (6) @(negedge mclk_in);
        `CHK({sda_oe_out, wr_en_out, pair_b_out}, 3'h0, "reset outs")
        `CHK(reg_addr_out, 16'h0000, "reset pointer")
        reset_n_in = 1'b1;
        int_strap_in = strap;
        repeat (4) @(negedge mclk_in);
        init_done_in = 1'b1;
        @(negedge mclk_in);
        init_done_in = 1'b0;
        repeat (2) @(negedge mclk_in);
    endtask

    task automatic t_int();
        event_in = 1'b1;
        `CHK(int_out, 1'b0, "interrupt early")
        @(negedge mclk_in);
        `CHK(int_out, 1'b1, "interrupt rise")
        event_in = 1'b0;
        @(negedge mclk_in);
        `CHK(int_out, 1'b0, "interrupt fall")
        `CHK(sda_oe_out, 1'b0, "idle drive")
    endtask

    task automatic t_write();
        wr_log.delete();
        host.bus_start();
        tb_send(8'hBA, 1'b0);
        tb_send(8'h12, 1'b0);
        tb_send(8'h34, 1'b0);
        tb_send(8'hAA, 1'b0);
        tb_send(8'h55, 1'b0);
        host.bus_stop();
        `CHK(wr_log.size(), 2, "write count")
        `CHK(wr_log[0], 24'h1234AA, "first write")
        `CHK(wr_log[1], 24'h123555, "second write")
        `CHK(reg_addr_out, 16'h1236, "write pointer")
        `CHK(sda_oe_out, 1'b0, "released after stop")
    endtask

    task automatic t_read();
        logic [7:0] d;
        rd_count = 0;
        host.bus_start();
        tb_send(8'hBA, 1'b0);
        tb_send(8'h00, 1'b0);
        tb_send(8'h10, 1'b0);
        host.bus_start();
        tb_send(8'hBB, 1'b0);
        host.read_byte(1'b0, d);
        `CHK(d, 8'hD3, "first read")
        host.read_byte(1'b1, d);
        `CHK(d, 8'hD2, "second read")
        host.bus_stop();
        `CHK(reg_addr_out, 16'h0012, "read pointer")
        `CHK(rd_count, 2, "read strobes")
    endtask

    task automatic t_wrong();
        wr_log.delete();
        host.bus_start();
        tb_send(8'h28, 1'b1);
        tb_send(8'h00, 1'b1);
        host.bus_stop();
        `CHK(wr_log.size(), 0, "stray write")
    endtask

    task automatic t_pair_b();
        t_reset(1'b1);
        `CHK(pair_b_out, 1'b1, "pair latched")
        int_strap_in = 1'b0;
        init_done_in = 1'b1;
        @(negedge mclk_in);
        init_done_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        `CHK(pair_b_out, 1'b1, "pair kept")
        host.bus_start();
        tb_send(8'hBA, 1'b1);
        host.bus_start();
        tb_send(8'h28, 1'b0);
        host.bus_stop();
    endtask

    initial begin
        t_reset(1'b0);
        t_int();
        t_write();
        t_read();
        t_wrong();
        t_pair_b();
        test_done();
    end
endmodule

`default_nettype wire
